// ### rtl/hms_regs.vh
// Notes on behaviour
// - All control happens over the serial slave port.
// - Clock-low timeout aborts transfer; can be disabled.
// - Either of two pins can act as alert.
// - Channels: 2.5 V input, supply, local, two remotes.
// - Channels are measured in fixed repeating order.
// - Delay follows each full pass before the next.
// - Each result lands in its value register.
// - Out-of-limit results set readable status bits.
// - Enable strap low: select strap picks address.
// - Enable strap high: address is 0x2E.
// - Alert driven low on any unmasked status bit.
// - Every status event has its own mask bit.
// - Address latched on first matching transaction.
// - First written byte loads the address pointer.
`ifndef HMS_REGS_VH
`define HMS_REGS_VH

// ****************************************
// Slave addresses
// ****************************************
`define HMS_ADDR_DEFAULT 7'h2E
`define HMS_ADDR_SEL_LO  7'h2C
`define HMS_ADDR_SEL_HI  7'h2D

// ****************************************
// Register map
// ****************************************
`define HMS_REG_VALUE0   8'h20
`define HMS_REG_LOW0     8'h44
`define HMS_REG_HIGH0    8'h45
`define HMS_REG_CONFIG   8'h40
`define HMS_REG_STATUS   8'h41
`define HMS_REG_MASK     8'h74
`define HMS_REG_CONFIG3  8'h78

// ****************************************
// Configuration fields
// ****************************************
`define HMS_CFG_START    0
`define HMS_CFG3_ALERT_A 0
`define HMS_CFG3_ALERT_B 1
`define HMS_CFG3_TO_DIS  2
`define HMS_CFG_RESET    8'h00
`define HMS_CFG3_RESET   8'h00
`define HMS_MASK_RESET   8'h00
`define HMS_LOW_RESET    8'h00
`define HMS_HIGH_RESET   8'hFF

// ****************************************
// Timing
// ****************************************
`define HMS_CLK_HZ       10000000
`define HMS_TIMEOUT_MS   25
`define HMS_TIMEOUT_CYC  (`HMS_CLK_HZ / 1000 * `HMS_TIMEOUT_MS)
`define HMS_NUM_CHAN     5

`endif

// ### rtl/hms_sync.v
`timescale 1ns/1ps
// ****************************************
// Two-stage synchroniser
// ****************************************
module hms_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset.
  input  wire CLOCK,
  input  wire RST,
  // Data.
  input  wire D,
  output wire Q
);
  reg s1_q;
  reg s2_q;

  // The first stage feeds only the second.
  always @(posedge CLOCK) begin
    if (RST) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
    end else begin
      s1_q <= D;
      s2_q <= s1_q;
    end
  end

  assign Q = s2_q;
endmodule

// ### rtl/hms_chan.v
`timescale 1ns/1ps
// ****************************************
// One channel: value, limits and comparison
// ****************************************
module hms_chan (
  // Clock and reset.
  input  wire       CLOCK,
  input  wire       RST,
  // Measurement.
  input  wire       LOAD,
  input  wire [7:0] SAMPLE,
  // Limit programming.
  input  wire       WR_LOW,
  input  wire       WR_HIGH,
  input  wire [7:0] WDATA,
  // State.
  output reg  [7:0] VALUE,
  output reg  [7:0] LOW,
  output reg  [7:0] HIGH,
  output wire       OUT_OF_LIMIT
);
  `include "hms_regs.vh"

  // Stores each completed measurement and the limits.
  always @(posedge CLOCK) begin
    if (RST) begin
      VALUE <= 8'h00;
      LOW   <= `HMS_LOW_RESET;
      HIGH  <= `HMS_HIGH_RESET;
    end else begin
      if (LOAD)
        VALUE <= SAMPLE;
      if (WR_LOW)
        LOW <= WDATA;
      if (WR_HIGH)
        HIGH <= WDATA;
    end
  end

  // Compare the fresh sample with the limits.
  assign OUT_OF_LIMIT = LOAD && ((SAMPLE < LOW) || (SAMPLE > HIGH));
endmodule

// ### rtl/hms_top.v
`timescale 1ns/1ps
`include "hms_regs.vh"
// ****************************************
// Monitor sequencer with serial slave port
// ****************************************
module hms_top #(
  parameter TIMEOUT_CYC = `HMS_TIMEOUT_CYC,
  parameter CONV_CYC    = 64,
  parameter PASS_DELAY  = 1000
) (
  // Clock and reset.
  input  wire       CLOCK,
  input  wire       RST,
  // Serial bus pins.
  input  wire       SCL_IN,
  input  wire       SDA_IN,
  output wire       SDA_OUT,
  output wire       SDA_OE,
  // Straps.
  input  wire       ADDRESS_ENABLE_STRAP,
  input  wire       ADDRESS_SELECT_STRAP,
  // Converter handshake.
  output wire [2:0] CONV_CHANNEL,
  output wire       CONV_START,
  input  wire       CONV_DONE,
  input  wire [7:0] CONV_DATA,
  // Alert pins, open drain.
  output wire       ALERT_A_OUT,
  output wire       ALERT_A_OE,
  output wire       ALERT_B_OUT,
  output wire       ALERT_B_OE
);

  localparam NCH = `HMS_NUM_CHAN;

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire scl;
  wire sda;
  wire en_strap;
  wire sel_strap;

  hms_sync #(.RESET_VAL(1'b1)) u_scl (.CLOCK(CLOCK), .RST(RST), .D(SCL_IN), .Q(scl));
  hms_sync #(.RESET_VAL(1'b1)) u_sda (.CLOCK(CLOCK), .RST(RST), .D(SDA_IN), .Q(sda));
  hms_sync #(.RESET_VAL(1'b1)) u_ena (.CLOCK(CLOCK), .RST(RST), .D(ADDRESS_ENABLE_STRAP),
                                      .Q(en_strap));
  hms_sync #(.RESET_VAL(1'b0)) u_sel (.CLOCK(CLOCK), .RST(RST), .D(ADDRESS_SELECT_STRAP),
                                      .Q(sel_strap));

  reg scl_p_q;
  reg sda_p_q;
  always @(posedge CLOCK) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire start_c  = scl & scl_p_q & sda_p_q & ~sda;
  wire stop_c   = scl & scl_p_q & ~sda_p_q & sda;

  // ****************************************
  // Configuration and status state
  // ****************************************
  reg  [7:0] cfg_q;
  reg  [7:0] cfg3_q;
  reg  [7:0] mask_q;
  reg  [7:0] status_q;
  reg  [7:0] ptr_q;
  reg  [6:0] addr_q;
  reg        addr_lock_q;
  reg        wr_en_q;

  // Slave address from straps until the first match locks it.
  wire [6:0] strap_addr = en_strap ? `HMS_ADDR_DEFAULT :
                          (sel_strap ? `HMS_ADDR_SEL_HI : `HMS_ADDR_SEL_LO);
  wire [6:0] my_addr    = addr_lock_q ? addr_q : strap_addr;

  // ****************************************
  // Channel sequencer
  // ****************************************
  localparam SQ_IDLE = 2'd0;
  localparam SQ_CONV = 2'd1;
  localparam SQ_WAIT = 2'd2;

  reg [1:0]  sq_q;
  reg [2:0]  ch_q;
  reg [15:0] dly_q;
  reg        start_q;

  // Steps through every channel, then rests before the next pass.
  always @(posedge CLOCK) begin
    if (RST) begin
      sq_q    <= SQ_IDLE;
      ch_q    <= 3'd0;
      dly_q   <= 16'h0000;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (sq_q)
        SQ_IDLE: begin
          ch_q <= 3'd0;
          if (cfg_q[`HMS_CFG_START]) begin
            sq_q    <= SQ_CONV;
            start_q <= 1'b1;
          end
        end
        SQ_CONV: begin
          if (CONV_DONE) begin
            if (ch_q == NCH - 1) begin
              ch_q  <= 3'd0;
              dly_q <= PASS_DELAY[15:0];
              sq_q  <= SQ_WAIT;
            end else begin
              ch_q    <= ch_q + 3'd1;
              start_q <= 1'b1;
            end
          end
        end
        SQ_WAIT: begin
          if (dly_q != 16'h0000)
            dly_q <= dly_q - 16'h0001;
          else if (cfg_q[`HMS_CFG_START]) begin
            sq_q    <= SQ_CONV;
            start_q <= 1'b1;
          end else
            sq_q <= SQ_IDLE;
        end
        default: sq_q <= SQ_IDLE;
      endcase
    end
  end

  assign CONV_CHANNEL = ch_q;
  assign CONV_START   = start_q;

  // ****************************************
  // Channel registers
  // ****************************************
  wire [NCH-1:0] oor;
  wire [7:0]     val_w  [0:NCH-1];
  wire [7:0]     low_w  [0:NCH-1];
  wire [7:0]     high_w [0:NCH-1];
  wire           wr_byte;
  wire [7:0]     wr_data;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      hms_chan u_ch (
        .CLOCK       (CLOCK),
        .RST         (RST),
        .LOAD        (sq_q == SQ_CONV && CONV_DONE && ch_q == g),
        .SAMPLE      (CONV_DATA),
        .WR_LOW      (wr_byte && ptr_q == `HMS_REG_LOW0 + 2 * g),
        .WR_HIGH     (wr_byte && ptr_q == `HMS_REG_HIGH0 + 2 * g),
        .WDATA       (wr_data),
        .VALUE       (val_w[g]),
        .LOW         (low_w[g]),
        .HIGH        (high_w[g]),
        .OUT_OF_LIMIT(oor[g])
      );
    end
  endgenerate

  // ****************************************
  // Serial slave
  // ****************************************
  localparam SL_IDLE = 3'd0;
  localparam SL_ADDR = 3'd1;
  localparam SL_AACK = 3'd2;
  localparam SL_WR   = 3'd3;
  localparam SL_WACK = 3'd4;
  localparam SL_RD   = 3'd5;
  localparam SL_RACK = 3'd6;

  reg [2:0]  sl_q;
  reg [3:0]  bit_q;
  reg [7:0]  sh_q;
  reg        rw_q;
  reg        first_q;
  reg        sda_drv_q;
  reg [31:0] low_cnt_q;
  reg [7:0]  rd_data;
  reg        status_rd_q;

  // Read mux over the register space.
  integer i;
  always @* begin
    rd_data = 8'h00;
    if (ptr_q == `HMS_REG_CONFIG)  rd_data = cfg_q;
    if (ptr_q == `HMS_REG_CONFIG3) rd_data = cfg3_q;
    if (ptr_q == `HMS_REG_MASK)    rd_data = mask_q;
    if (ptr_q == `HMS_REG_STATUS)  rd_data = status_q;
    for (i = 0; i < NCH; i = i + 1) begin
      if (ptr_q == `HMS_REG_VALUE0 + i)     rd_data = val_w[i];
      if (ptr_q == `HMS_REG_LOW0 + 2 * i)   rd_data = low_w[i];
      if (ptr_q == `HMS_REG_HIGH0 + 2 * i)  rd_data = high_w[i];
    end
  end

  wire timeout = ~cfg3_q[`HMS_CFG3_TO_DIS] && (low_cnt_q >= TIMEOUT_CYC);
  assign wr_byte = (sl_q == SL_WR) && scl_rise && (bit_q == 4'd7) && ~first_q;
  assign wr_data = {sh_q[6:0], sda};

  // Bit engine: address, pointer, data and acknowledge phases.
  always @(posedge CLOCK) begin
    if (RST) begin
      sl_q        <= SL_IDLE;
      bit_q       <= 4'd0;
      sh_q        <= 8'h00;
      rw_q        <= 1'b0;
      first_q     <= 1'b0;
      sda_drv_q   <= 1'b0;
      low_cnt_q   <= 32'd0;
      ptr_q       <= 8'h00;
      addr_q      <= `HMS_ADDR_DEFAULT;
      addr_lock_q <= 1'b0;
      wr_en_q     <= 1'b0;
      status_rd_q <= 1'b0;
    end else begin
      wr_en_q     <= 1'b0;
      status_rd_q <= 1'b0;
      low_cnt_q   <= scl ? 32'd0 : low_cnt_q + 32'd1;
      if (start_c) begin
        sl_q      <= SL_ADDR;
        bit_q     <= 4'd0;
        sda_drv_q <= 1'b0;
      end else if (stop_c || timeout) begin
        sl_q      <= SL_IDLE;
        sda_drv_q <= 1'b0;
        low_cnt_q <= 32'd0;
      end else if (scl_rise) begin
        case (sl_q)
          SL_ADDR, SL_WR: begin
            sh_q  <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'd1;
            if (sl_q == SL_ADDR && bit_q == 4'd6 && {sh_q[5:0], sda} == my_addr) begin
              addr_q      <= my_addr;
              addr_lock_q <= 1'b1;
            end
            if (sl_q == SL_WR && bit_q == 4'd7) begin
              if (first_q)
                ptr_q <= {sh_q[6:0], sda};
              else
                ptr_q <= ptr_q + 8'h01;
              first_q <= 1'b0;
            end
          end
          SL_RD: bit_q <= bit_q + 4'd1;
          SL_RACK: begin
            if (sda)
              sl_q <= SL_IDLE;
            else
              ptr_q <= ptr_q + 8'h01;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (sl_q)
          SL_ADDR: begin
            if (bit_q == 4'd8) begin
              if (sh_q[7:1] == my_addr) begin
                rw_q      <= sh_q[0];
                first_q   <= 1'b1;
                sda_drv_q <= 1'b1;
                sl_q      <= SL_AACK;
              end else
                sl_q <= SL_IDLE;
            end
          end
          SL_WR: begin
            if (bit_q == 4'd8) begin
              sda_drv_q <= 1'b1;
              sl_q      <= SL_WACK;
            end
          end
          SL_AACK, SL_WACK, SL_RACK: begin
            bit_q <= 4'd0;
            if (sl_q != SL_RACK && !rw_q) begin
              sda_drv_q <= 1'b0;
              sl_q      <= SL_WR;
            end else begin
              sh_q        <= rd_data;
              status_rd_q <= (ptr_q == `HMS_REG_STATUS);
              sda_drv_q   <= ~rd_data[7];
              sl_q        <= SL_RD;
            end
          end
          SL_RD: begin
            if (bit_q == 4'd8) begin
              sda_drv_q <= 1'b0;
              sl_q      <= SL_RACK;
            end else begin
              sda_drv_q <= ~sh_q[6];
              sh_q      <= {sh_q[6:0], 1'b0};
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_drv_q;

  // ****************************************
  // Config, mask and status registers
  // ****************************************
  always @(posedge CLOCK) begin
    if (RST) begin
      cfg_q    <= `HMS_CFG_RESET;
      cfg3_q   <= `HMS_CFG3_RESET;
      mask_q   <= `HMS_MASK_RESET;
      status_q <= 8'h00;
    end else begin
      if (wr_byte && ptr_q == `HMS_REG_CONFIG)  cfg_q  <= wr_data;
      if (wr_byte && ptr_q == `HMS_REG_CONFIG3) cfg3_q <= wr_data;
      if (wr_byte && ptr_q == `HMS_REG_MASK)    mask_q <= wr_data;
      // Read clears, but a fresh event in the same cycle wins.
      status_q <= (status_rd_q ? 8'h00 : status_q) | {{(8-NCH){1'b0}}, oor};
    end
  end

  // Alert drives low on any unmasked status bit.
  wire alert = |(status_q & ~mask_q);
  assign ALERT_A_OUT = 1'b0;
  assign ALERT_B_OUT = 1'b0;
  assign ALERT_A_OE  = cfg3_q[`HMS_CFG3_ALERT_A] & alert;
  assign ALERT_B_OE  = cfg3_q[`HMS_CFG3_ALERT_B] & alert;
endmodule

// ### verif/hms_top_chk.sv
`timescale 1ns/1ps
// ********
// Port checker for the monitor sequencer
// ********
module hms_top_chk #(
  parameter PASS_DELAY = 1000
) (
  // Clock and reset.
  input wire       CLOCK,
  input wire       RST,
  // Serial bus pins.
  input wire       SCL_IN,
  input wire       SDA_OE,
  // Converter handshake.
  input wire [2:0] CONV_CHANNEL,
  input wire       CONV_START,
  input wire       CONV_DONE,
  // Alert pins.
  input wire       ALERT_A_OUT,
  input wire       ALERT_A_OE,
  input wire       ALERT_B_OUT,
  input wire       ALERT_B_OE
);
  localparam int PD_LO = PASS_DELAY - 1;
  localparam int PD_HI = PASS_DELAY + 8;
  reg        busy_q;
  reg        seen_q;
  reg [2:0]  last_q;
  reg [15:0] gap_q;
  wire [2:0] next_ch = (last_q == 3'h4) ? 3'h0 : last_q + 3'h1;
  default clocking dc @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // Tracks the open conversion, the last channel and the idle time after a pass.
  always @(posedge CLOCK) begin
    if (RST) begin
      busy_q <= 1'h0;
      seen_q <= 1'h0;
      last_q <= 3'h0;
      gap_q  <= 16'hFFFF;
    end else begin
      if (CONV_START) begin
        busy_q <= 1'h1;
        seen_q <= 1'h1;
        last_q <= CONV_CHANNEL;
      end else if (CONV_DONE) begin
        busy_q <= 1'h0;
      end
      if (CONV_DONE && busy_q && last_q == 3'h4) begin
        gap_q <= 16'h0000;
      end else if (gap_q != 16'hFFFF) begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end
  sequence pass_end;
    CONV_DONE && busy_q && last_q == 3'h4;
  endsequence
  sequence chan_end;
    CONV_DONE && busy_q && last_q != 3'h4;
  endsequence
  sequence alert_up;
    $rose(ALERT_A_OE) || $rose(ALERT_B_OE);
  endsequence
  a_start_single: assert property (CONV_START |=> !CONV_START)
    else $error("start pulse too long");
  a_chan_order: assert property (CONV_START |-> CONV_CHANNEL == (seen_q ? next_ch : 3'h0))
    else $error("channel out of order");
  a_chan_hold: assert property (busy_q |-> $stable(CONV_CHANNEL))
    else $error("channel moved mid conversion");
  a_one_conv: assert property (busy_q |-> !CONV_START)
    else $error("second start while busy");
  a_chan_next: assert property (chan_end |=> CONV_START)
    else $error("next channel not started");
  a_pass_wait: assert property (pass_end |-> ##[PD_LO:PD_HI] CONV_START)
    else $error("next pass late");
  a_pass_gap: assert property (CONV_START && seen_q && last_q == 3'h4 |-> gap_q >= PD_LO)
    else $error("next pass early");
  a_sda_low_clock: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data moved while clock high");
  a_alert_drive: assert property (!(ALERT_A_OE && ALERT_A_OUT))
    else $error("alert A not driven low");
  a_alert_low_b: assert property (!(ALERT_B_OE && ALERT_B_OUT))
    else $error("alert B not driven low");
  a_alert_cause: assert property (alert_up |-> $past(CONV_DONE) || SCL_IN)
    else $error("alert rose with no result or bus write");
endmodule
bind hms_top hms_top_chk #(.PASS_DELAY(PASS_DELAY)) chk (
  .CLOCK        (CLOCK),
  .RST          (RST),
  .SCL_IN       (SCL_IN),
  .SDA_OE       (SDA_OE),
  .CONV_CHANNEL (CONV_CHANNEL),
  .CONV_START   (CONV_START),
  .CONV_DONE    (CONV_DONE),
  .ALERT_A_OUT  (ALERT_A_OUT),
  .ALERT_A_OE   (ALERT_A_OE),
  .ALERT_B_OUT  (ALERT_B_OUT),
  .ALERT_B_OE   (ALERT_B_OE)
);

// ### verif/hms_host.sv
`timescale 1ns/1ps
// ********
// Serial bus master standing in for the host controller
// ********
module hms_host #(
  parameter HALF = 14
) (
  // Clock.
  input  wire clock,
  // Bus lines; data released goes high through the pull-up.
  input  wire sda,
  output reg  scl,
  output reg  sda_drv
);
  // Idle bus.
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Start: data falls while the clock is high; works as a repeated start too.
  task automatic bus_start();
    wt(2);
    sda_drv = 1'h1;
    wt(HALF);
    scl = 1'h1;
    wt(HALF);
    sda_drv = 1'h0;
    wt(HALF);
    scl = 1'h0;
  endtask
  task automatic bus_stop();
    wt(2);
    sda_drv = 1'h0;
    wt(HALF);
    scl = 1'h1;
    wt(HALF);
    sda_drv = 1'h1;
    wt(HALF);
  endtask
  // Data changes only a little after the clock has fallen, so no false start or stop.
  task automatic bus_bit(input logic b, input int stall, output logic r);
    wt(2);
    sda_drv = b;
    wt(HALF + stall);
    scl = 1'h1;
    wt(HALF);
    r = sda;
    scl = 1'h0;
  endtask
  task automatic bus_byte(input logic [7:0] tx, input logic ackb, input int stall,
                          output logic [7:0] rx, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(tx[i], 0, b);
      rx[i] = b;
    end
    bus_bit(ackb, stall, b);
    ack = ~b;
  endtask
  // Write: address, pointer byte, then n data bytes, high byte first.
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    input int n, input int stall, output logic k);
    logic [7:0] r;
    logic       x;
    bus_start();
    bus_byte({a, 1'h0}, 1'h1, 0, r, k);
    if (k) begin
      bus_byte(p, 1'h1, stall, r, x);
      k = x;
      for (int i = n - 1; i >= 0; i--) begin
        bus_byte(d[8*i+:8], 1'h1, 0, r, x);
      end
    end
    bus_stop();
  endtask
  // Read: set the pointer, then read n bytes and refuse the last.
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n,
                    output logic [15:0] q);
    logic [7:0] r;
    logic       k;
    wr(a, p, 16'h0000, 0, 0, k);
    bus_start();
    bus_byte({a, 1'h1}, 1'h1, 0, r, k);
    q = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      bus_byte(8'hFF, i == 0, 0, r, k);
      q[8*i+:8] = r;
    end
    bus_stop();
  endtask
endmodule

// ### verif/tb_hw_monitor_sequencer_smbus.sv
`timescale 1ns/1ps
`include "hms_regs.vh"
// ********
// Bench for the monitor sequencer
// ********
module tb_hw_monitor_sequencer_smbus;
  localparam int   PDLY = 40;
  localparam int   TOUT = 200;
  localparam [6:0] ADR  = `HMS_ADDR_SEL_HI;
  reg          clock;
  reg          rst;
  reg          aen;
  reg          asel;
  reg          cdone;
  reg  [7:0]   cdata;
  wire         scl;
  wire         sda_drv;
  wire         sda_oe;
  wire [2:0]   chan;
  wire         start;
  wire         al_a_oe;
  wire         al_b_oe;
  wire         sda = sda_drv & ~sda_oe;
  int unsigned seed = 80;
  int          num_errors = 0;
  int          num_checks = 0;
  int          val[5];
  int          lo[5];
  int          hi[5];
  logic [4:0]  st = 5'h00;
  logic [15:0] q;
  logic [7:0]  cfg;
  logic [7:0]  msk;
  logic        k;
  logic        frz = 1'h0;
  hms_top #(.TIMEOUT_CYC(TOUT), .PASS_DELAY(PDLY)) uut (
    .CLOCK                (clock),
    .RST                  (rst),
    .SCL_IN               (scl),
    .SDA_IN               (sda),
    .SDA_OUT              (),
    .SDA_OE               (sda_oe),
    .ADDRESS_ENABLE_STRAP (aen),
    .ADDRESS_SELECT_STRAP (asel),
    .CONV_CHANNEL         (chan),
    .CONV_START           (start),
    .CONV_DONE            (cdone),
    .CONV_DATA            (cdata),
    .ALERT_A_OUT          (),
    .ALERT_A_OE           (al_a_oe),
    .ALERT_B_OUT          (),
    .ALERT_B_OE           (al_b_oe)
  );
  hms_host #(.HALF(14)) host (
    .clock   (clock),
    .sda     (sda),
    .scl     (scl),
    .sda_drv (sda_drv)
  );
  function automatic int unsigned rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic boot(input logic en, input logic sel);
    rst = 1'h1;
    aen = en;
    asel = sel;
    tick(12);
    rst = 1'h0;
    tick(4);
  endtask
  // Clock.
  initial begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  // Converter stand-in: random result after a random wait, held back while frozen.
  initial begin
    int ch;
    int i;
    cdone = 1'h0;
    cdata = 8'h00;
    forever begin
      if (start === 1'h1) begin
        ch = chan;
        tick(1 + rnd() % 6);
        for (i = 0; frz && i < 30000; i++) begin
          tick(1);
        end
        if (i == 30000) begin
          chk(16'h0001, 16'h0000);
          stop_test();
        end
        cdata = 8'(rnd());
        cdone = 1'h1;
        val[ch] = cdata;
        if (cdata < lo[ch] || cdata > hi[ch]) begin
          st[ch] = 1'h1;
        end
        tick(1);
        cdone = 1'h0;
      end else begin
        tick(1);
      end
    end
  end
  // Main sequence.
  initial begin
    for (int c = 0; c < 5; c++) begin
      lo[c] = 0;
      hi[c] = 255;
    end
    boot(1'h1, 1'h0);
    host.wr(`HMS_ADDR_DEFAULT, `HMS_REG_CONFIG, 16'h0000, 0, 0, k);
    chk(16'(k), 16'h0001);
    host.wr(`HMS_ADDR_SEL_LO, `HMS_REG_CONFIG, 16'h0000, 0, 0, k);
    chk(16'(k), 16'h0000);
    boot(1'h0, 1'h1);
    host.wr(`HMS_ADDR_DEFAULT, `HMS_REG_CONFIG, 16'h0000, 0, 0, k);
    chk(16'(k), 16'h0000);
    host.wr(ADR, `HMS_REG_CONFIG, 16'h0000, 0, 0, k);
    chk(16'(k), 16'h0001);
    aen = 1'h1;
    asel = 1'h0;
    host.wr(ADR, `HMS_REG_CONFIG, 16'h0000, 0, 0, k);
    chk(16'(k), 16'h0001);
    host.wr(`HMS_ADDR_DEFAULT, `HMS_REG_CONFIG, 16'h0000, 0, 0, k);
    chk(16'(k), 16'h0000);
    // Limits go in with the pointer stepping on by itself.
    host.wr(ADR, `HMS_REG_LOW0, 16'h40C0, 2, 0, k);
    host.wr(ADR, `HMS_REG_LOW0 + 8'h06, 16'h6090, 2, 0, k);
    host.rd(ADR, `HMS_REG_LOW0, 2, q);
    chk(q, 16'h40C0);
    lo[0] = 64;
    hi[0] = 192;
    lo[3] = 96;
    hi[3] = 144;
    host.wr(ADR, `HMS_REG_CONFIG, 16'h0001, 1, 0, k);
    // Each round picks an alert pin and a mask, then checks with the converter frozen.
    for (int r = 0; r < 4; r++) begin
      cfg = r[0] ? 8'h02 : 8'h01;
      msk = r[1] ? 8'h09 : 8'h00;
      host.wr(ADR, `HMS_REG_CONFIG3, 16'(cfg), 1, 0, k);
      host.wr(ADR, `HMS_REG_MASK, 16'(msk), 1, 0, k);
      tick(300);
      frz = 1'h1;
      tick(20);
      chk(16'(al_a_oe), 16'(cfg[0] & |(st & ~msk[4:0])));
      chk(16'(al_b_oe), 16'(cfg[1] & |(st & ~msk[4:0])));
      for (int c = 0; c < 5; c++) begin
        host.rd(ADR, 8'(`HMS_REG_VALUE0 + c), 1, q);
        chk(q, 16'(val[c]));
      end
      host.rd(ADR, `HMS_REG_STATUS, 1, q);
      chk(q, 16'(st));
      st = 5'h00;
      chk(16'(al_a_oe | al_b_oe), 16'h0000);
      frz = 1'h0;
    end
    host.wr(ADR, `HMS_REG_CONFIG, 16'h0000, 0, TOUT + 60, k);
    chk(16'(k), 16'h0000);
    host.wr(ADR, `HMS_REG_CONFIG3, 16'h0004, 1, 0, k);
    host.wr(ADR, `HMS_REG_CONFIG, 16'h0000, 0, TOUT + 60, k);
    chk(16'(k), 16'h0001);
    stop_test();
  end
endmodule
